// *** logic/tsm_master.sv ***
// Purpose: bus master that reads and writes the temperature sensor
// Assumes: open-drain lines with pull-ups; no clock stretching
// Notes: one command at a time; answer is a one-cycle pulse
`timescale 1ns/1ns
`default_nettype none
module tsm_master #(
    parameter logic [15:0] QUARTER_CYC = 16'(tsm_pkg::QUARTER_CYC),
    parameter logic [31:0] FREE_TIMEOUT_CYC =
        32'(tsm_pkg::FREE_TIMEOUT_CYC),
    // type code is arbitrary here; set it to the fitted sensor's code
    parameter logic [3:0] DEV_TYPE = 4'h5
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ce,
    input wire logic cmd_valid,
    input wire tsm_pkg::tsm_cmd_t cmd,
    output logic cmd_ready,
    output logic rsp_valid,
    output tsm_pkg::tsm_rsp_t rsp,
    output logic [1:0] ptr_mirror,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe
);

    // ********************************
    // state
    // ********************************
    typedef struct packed {
        tsm_pkg::tsm_state_t st;
        tsm_pkg::tsm_seg_t seg;
        logic [1:0] ph;
        logic [15:0] qcnt;
        logic [3:0] bitn;
        logic [7:0] sh;
        logic two;
        tsm_pkg::tsm_cmd_t cmd;
        logic [1:0] ptr_m;
        logic [31:0] tocnt;
        logic scl_oe;
        logic sda_oe;
        logic cmd_ready;
        logic rsp_valid;
        tsm_pkg::tsm_rsp_t rsp;
    } tsm_regs_t;

    tsm_regs_t s_r;
    tsm_regs_t s_nxt;
    logic [1:0] pins_s;
    logic scl_s;
    logic sda_s;

    function automatic logic [7:0] tsm_addr_byte(
        input logic [2:0] sel,
        input logic dir
    );
        tsm_addr_byte = {DEV_TYPE, sel, dir};
    endfunction : tsm_addr_byte

    function automatic logic tsm_is_two(input logic [1:0] p);
        tsm_is_two = (p != tsm_pkg::PTR_CONF);
    endfunction : tsm_is_two

    tsm_sync #(
        .W(2)
    ) u_sync (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .ce(ce),
        .async_in({scl_in, sda_in}),
        .sync_out(pins_s)
    );
    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];

    // ********************************
    // sequencer
    // ********************************
    always_comb begin
        logic tick;
        logic ack;
        logic [15:0] keep;
        tick = 1'b0;
        ack = 1'b0;
        keep = 16'hffff;
        s_nxt = s_r;
        s_nxt.rsp_valid = 1'b0;
        if (s_r.st != tsm_pkg::TSM_IDLE && s_r.st != tsm_pkg::TSM_DONE) begin
            if (s_r.qcnt == 16'h0000) begin
                tick = 1'b1;
                s_nxt.qcnt = QUARTER_CYC - 16'h0001;
                s_nxt.ph = s_r.ph + 2'h1;
            end else begin
                s_nxt.qcnt = s_r.qcnt - 16'h0001;
            end
        end
        if (s_r.cmd.ptr == tsm_pkg::PTR_LOWER
            || s_r.cmd.ptr == tsm_pkg::PTR_UPPER) begin
            keep = tsm_pkg::THR_KEEP_MASK;
        end
        unique case (s_r.st)
            tsm_pkg::TSM_IDLE: begin
                s_nxt.cmd_ready = 1'b1;
                if (cmd_valid && s_r.cmd_ready) begin
                    s_nxt.cmd_ready = 1'b0;
                    s_nxt.cmd = cmd;
                    s_nxt.rsp = '0;
                    s_nxt.tocnt = 32'h0;
                    s_nxt.qcnt = QUARTER_CYC - 16'h0001;
                    s_nxt.ph = 2'h0;
                    s_nxt.st = tsm_pkg::TSM_FREE;
                    // temperature register is read-only
                    if (cmd.op == tsm_pkg::TSM_OP_WRITE
                        && cmd.ptr == tsm_pkg::PTR_TEMP) begin
                        s_nxt.rsp.err = 1'b1;
                        s_nxt.st = tsm_pkg::TSM_DONE;
                    end
                end
            end
            tsm_pkg::TSM_FREE: begin
                // wait for both lines high for one quarter
                s_nxt.ph = 2'h0;
                if (!(scl_s && sda_s)) begin
                    s_nxt.qcnt = QUARTER_CYC - 16'h0001;
                    s_nxt.tocnt = s_r.tocnt + 32'h1;
                    if (s_r.tocnt >= FREE_TIMEOUT_CYC - 32'h1) begin
                        // stuck line: keep released, report, end the command
                        s_nxt.rsp.err = 1'b1;
                        s_nxt.st = tsm_pkg::TSM_DONE;
                    end
                end else if (tick) begin
                    s_nxt.st = tsm_pkg::TSM_START;
                    if (s_r.cmd.op == tsm_pkg::TSM_OP_READ) begin
                        // preset pointer: straight to the read address
                        s_nxt.seg = tsm_pkg::TSM_SEG_ADDRR;
                        s_nxt.sh = tsm_addr_byte(s_r.cmd.dev_sel,
                            tsm_pkg::ADDR_DIR_READ);
                    end else begin
                        s_nxt.seg = tsm_pkg::TSM_SEG_ADDRW;
                        s_nxt.sh = tsm_addr_byte(s_r.cmd.dev_sel,
                            tsm_pkg::ADDR_DIR_WRITE);
                    end
                end
            end
            tsm_pkg::TSM_START: begin
                // also used for the repeated start before a read
                if (tick) begin
                    unique case (s_r.ph)
                        2'h0: s_nxt.sda_oe = 1'b0;
                        2'h1: s_nxt.scl_oe = 1'b0;
                        2'h2: s_nxt.sda_oe = 1'b1;
                        2'h3: begin
                            s_nxt.scl_oe = 1'b1;
                            s_nxt.bitn = 4'h0;
                            s_nxt.st = tsm_pkg::TSM_XFER;
                        end
                    endcase
                end
            end
            tsm_pkg::TSM_XFER: begin
                if (tick) begin
                    unique case (s_r.ph)
                        2'h0: begin
                            // data moves only with the clock low
                            if (s_r.bitn == tsm_pkg::ACK_BIT_IDX) begin
                                // ack while more bytes are wanted
                                s_nxt.sda_oe =
                                    (s_r.seg == tsm_pkg::TSM_SEG_RDATA)
                                    && s_r.two;
                            end else if (s_r.seg == tsm_pkg::TSM_SEG_RDATA)
                            begin
                                s_nxt.sda_oe = 1'b0;
                            end else begin
                                s_nxt.sda_oe = ~s_r.sh[7];
                            end
                        end
                        2'h1: s_nxt.scl_oe = 1'b0;
                        2'h2: s_nxt.scl_oe = 1'b0;
                        2'h3: begin
                            s_nxt.scl_oe = 1'b1;
                            if (s_r.bitn != tsm_pkg::ACK_BIT_IDX) begin
                                s_nxt.sh = {s_r.sh[6:0], sda_s};
                                s_nxt.bitn = s_r.bitn + 4'h1;
                            end else begin
                                s_nxt.bitn = 4'h0;
                                ack = ~sda_s;
                                if (s_r.seg != tsm_pkg::TSM_SEG_RDATA
                                    && !ack) begin
                                    s_nxt.rsp.err = 1'b1;
                                    s_nxt.st = tsm_pkg::TSM_STOP;
                                end else begin
                                    unique case (s_r.seg)
                                        tsm_pkg::TSM_SEG_ADDRW: begin
                                            s_nxt.seg = tsm_pkg::TSM_SEG_PTR;
                                            s_nxt.sh = {tsm_pkg::PTR_UPPER_ZERO,
                                                s_r.cmd.ptr};
                                        end
                                        tsm_pkg::TSM_SEG_PTR: begin
                                            s_nxt.ptr_m = s_r.cmd.ptr;
                                            unique case (s_r.cmd.op)
                                                tsm_pkg::TSM_OP_WRITE: begin
                                                    s_nxt.seg =
                                                        tsm_pkg::TSM_SEG_WDATA;
                                                    s_nxt.two =
                                                        tsm_is_two(s_r.cmd.ptr);
                                                    s_nxt.sh = s_nxt.two ?
                                                        s_r.cmd.wdata[15:8] :
                                                        s_r.cmd.wdata[7:0];
                                                end
                                                tsm_pkg::TSM_OP_SETREAD: begin
                                                    s_nxt.seg =
                                                        tsm_pkg::TSM_SEG_ADDRR;
                                                    s_nxt.sh = tsm_addr_byte(
                                                        s_r.cmd.dev_sel,
                                                        tsm_pkg::ADDR_DIR_READ);
                                                    s_nxt.ph = 2'h0;
                                                    s_nxt.st =
                                                        tsm_pkg::TSM_START;
                                                end
                                                default: begin
                                                    s_nxt.st =
                                                        tsm_pkg::TSM_STOP;
                                                end
                                            endcase
                                        end
                                        tsm_pkg::TSM_SEG_WDATA: begin
                                            if (s_r.two) begin
                                                s_nxt.two = 1'b0;
                                                s_nxt.sh = s_r.cmd.wdata[7:0]
                                                    & keep[7:0];
                                            end else begin
                                                s_nxt.st = tsm_pkg::TSM_STOP;
                                            end
                                        end
                                        tsm_pkg::TSM_SEG_ADDRR: begin
                                            s_nxt.seg = tsm_pkg::TSM_SEG_RDATA;
                                            s_nxt.two = tsm_is_two(s_r.ptr_m);
                                        end
                                        tsm_pkg::TSM_SEG_RDATA: begin
                                            s_nxt.rsp.data =
                                                {s_r.rsp.data[7:0], s_r.sh};
                                            if (s_r.two) begin
                                                s_nxt.two = 1'b0;
                                            end else begin
                                                s_nxt.st = tsm_pkg::TSM_STOP;
                                            end
                                        end
                                        default: begin
                                            s_nxt.rsp.err = 1'b1;
                                            s_nxt.st = tsm_pkg::TSM_STOP;
                                        end
                                    endcase
                                end
                            end
                        end
                    endcase
                end
            end
            tsm_pkg::TSM_STOP: begin
                if (tick) begin
                    unique case (s_r.ph)
                        2'h0: s_nxt.sda_oe = 1'b1;
                        2'h1: s_nxt.scl_oe = 1'b0;
                        2'h2: s_nxt.sda_oe = 1'b0;
                        2'h3: s_nxt.st = tsm_pkg::TSM_DONE;
                    endcase
                end
            end
            tsm_pkg::TSM_DONE: begin
                s_nxt.scl_oe = 1'b0;
                s_nxt.sda_oe = 1'b0;
                s_nxt.rsp_valid = 1'b1;
                s_nxt.cmd_ready = 1'b1;
                s_nxt.st = tsm_pkg::TSM_IDLE;
            end
            default: begin
                s_nxt.scl_oe = 1'b0;
                s_nxt.sda_oe = 1'b0;
                s_nxt.st = tsm_pkg::TSM_IDLE;
            end
        endcase
    end

    // reset leaves both lines released and the pointer mirror at zero
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    // ********************************
    // outputs
    // ********************************
    assign cmd_ready = s_r.cmd_ready;
    assign rsp_valid = s_r.rsp_valid;
    assign rsp = s_r.rsp;
    assign ptr_mirror = s_r.ptr_m;
    assign scl_oe = s_r.scl_oe;
    assign sda_oe = s_r.sda_oe;
    // open drain: only ever drive low
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;

endmodule : tsm_master
`default_nettype wire

// *** logic/tsm_pkg.sv ***
// Purpose: shared constants and types for the temperature sensor master
// Assumes: 100 MHz system clock, sensor on a two-wire serial bus
// Notes: the sensor register map here is used by the master logic and the sensor model
//
// How it works
// - master starts every transfer and drives clock
// - nine clocks per byte: eight data, one acknowledge
// - master starts only when both lines high
// - start: data falls, stop: data rises, clock high
// - data changes only while clock is low
// - receiver pulls data low during ninth clock
// - master reader does not acknowledge last byte
// - write address then pointer byte
// - read reuses pointer or follows pointer write
// - complete byte and acknowledge clocks, no gaps
package tsm_pkg;

    // ********************************
    // timing
    // ********************************
    localparam int CLK_NS = 10;
    localparam int T_QUARTER_NS = 2500;
    localparam int QUARTER_CYC = (T_QUARTER_NS + CLK_NS - 1) / CLK_NS;
    localparam int T_FREE_TIMEOUT_US = 10000;
    localparam int FREE_TIMEOUT_CYC = T_FREE_TIMEOUT_US * 1000 / CLK_NS;

    // ********************************
    // sensor register map
    // ********************************
    localparam logic [1:0] PTR_TEMP = 2'h0;
    localparam logic [1:0] PTR_CONF = 2'h1;
    localparam logic [1:0] PTR_LOWER = 2'h2;
    localparam logic [1:0] PTR_UPPER = 2'h3;
    localparam logic [1:0] PTR_RESET = 2'h0;
    localparam logic [15:0] UPPER_THR_RESET = 16'h5000;
    localparam logic [15:0] LOWER_THR_RESET = 16'h4b00;
    localparam logic [7:0] CONF_RESET = 8'h00;
    localparam logic [15:0] THR_KEEP_MASK = 16'hfff0;
    localparam logic [5:0] PTR_UPPER_ZERO = 6'h00;
    localparam logic [3:0] ACK_BIT_IDX = 4'h8;
    localparam logic ADDR_DIR_WRITE = 1'b0;
    localparam logic ADDR_DIR_READ = 1'b1;

    // ********************************
    // types
    // ********************************
    typedef enum logic [1:0] {
        TSM_OP_READ = 2'h0,
        TSM_OP_SETREAD = 2'h1,
        TSM_OP_WRITE = 2'h2,
        TSM_OP_POINT = 2'h3
    } tsm_op_t;

    typedef enum logic [2:0] {
        TSM_IDLE = 3'h0,
        TSM_FREE = 3'h1,
        TSM_START = 3'h3,
        TSM_XFER = 3'h2,
        TSM_STOP = 3'h6,
        TSM_DONE = 3'h7
    } tsm_state_t;

    typedef enum logic [2:0] {
        TSM_SEG_ADDRW = 3'h0,
        TSM_SEG_PTR = 3'h1,
        TSM_SEG_WDATA = 3'h3,
        TSM_SEG_ADDRR = 3'h2,
        TSM_SEG_RDATA = 3'h6
    } tsm_seg_t;

    typedef struct packed {
        tsm_op_t op;
        logic [2:0] dev_sel;
        logic [1:0] ptr;
        logic [15:0] wdata;
    } tsm_cmd_t;

    typedef struct packed {
        logic err;
        logic [15:0] data;
    } tsm_rsp_t;

endpackage : tsm_pkg

// *** logic/tsm_sync.sv ***
// Purpose: two-stage synchroniser for asynchronous pin inputs
// Assumes: inputs idle high, as on a pulled-up bus
// Notes: first stage feeds only the second stage
`timescale 1ns/1ns
`default_nettype none
module tsm_sync #(
    parameter int W = 2
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic meta_r;
            logic hold_r;
            always_ff @(posedge clk_sys or negedge resetn) begin
                if (!resetn) begin
                    meta_r <= 1'b1;
                    hold_r <= 1'b1;
                end else if (ce) begin
                    meta_r <= async_in[i];
                    hold_r <= meta_r;
                end
            end
            assign sync_out[i] = hold_r;
        end
    endgenerate
endmodule : tsm_sync
`default_nettype wire

// *** test/tb_tsm_master.sv ***
// Purpose: self-checking bench for the sensor bus master
// Assumes: short quarter and bus-free timeout for run time
// Notes: lines resolve as wired-and with pull-ups
`timescale 1ns/1ns
`default_nettype none
module tb_tsm_master;
    localparam tsm_pkg::tsm_op_t RD = tsm_pkg::TSM_OP_READ;
    localparam tsm_pkg::tsm_op_t SR = tsm_pkg::TSM_OP_SETREAD;
    localparam tsm_pkg::tsm_op_t WR = tsm_pkg::TSM_OP_WRITE;
    localparam tsm_pkg::tsm_op_t PT = tsm_pkg::TSM_OP_POINT;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic cmd_valid = 1'b0;
    logic hold_low = 1'b0;
    logic ce = 1'b1;
    tsm_pkg::tsm_cmd_t cmd = '0;
    tsm_pkg::tsm_rsp_t rsp;
    logic cmd_ready, rsp_valid, scl_oe, sda_oe, dev_oe;
    logic [1:0] ptr_mirror;
    wire logic scl_w;
    wire logic sda_w;
    int errors = 0;
    int checked = 0;
    always #5 clk_sys = ~clk_sys;
    assign scl_w = ~scl_oe;
    assign sda_w = ~(sda_oe | dev_oe | hold_low);
    tsm_master #(.QUARTER_CYC(16'h4), .FREE_TIMEOUT_CYC(32'h40)) dut_u (
        .clk_sys(clk_sys), .resetn(resetn), .ce(ce),
        .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
        .rsp_valid(rsp_valid), .rsp(rsp), .ptr_mirror(ptr_mirror),
        .scl_in(scl_w), .scl_out(), .scl_oe(scl_oe),
        .sda_in(sda_w), .sda_out(), .sda_oe(sda_oe));
    tsm_sensor_model #(.DEV_TYPE(4'h5), .PINS(3'h2)) dev_u (
        .scl(scl_w), .sda(sda_w), .sda_oe(dev_oe));
    // ****
    // tasks
    // ****
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic print_verdict();
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict
    // one command, held until taken, then wait for its answer
    task automatic run(input tsm_pkg::tsm_op_t op, input logic [2:0] sel,
            input logic [1:0] ptr, input logic [15:0] wd,
            input logic [15:0] exp, input logic err);
        int k;
        cmd_valid <= 1'b1;
        cmd <= '{op, sel, ptr, wd};
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (cmd_ready !== 1'b1 && k < 50);
        cmd_valid <= 1'b0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (rsp_valid !== 1'b1 && k < 5000);
        if (k >= 5000) begin
            errors++;
            print_verdict();
        end
        check({15'h0, rsp.err}, {15'h0, err});
        if (!err) check(rsp.data, exp);
    endtask : run
    // ****
    // sequence
    // ****
    initial begin
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (2) @(posedge clk_sys);
        check({15'h0, cmd_ready}, 16'h1);
        check({14'h0, ptr_mirror}, 16'h0);
        // frozen by ce: a waiting command must not be taken
        ce <= 1'b0;
        cmd_valid <= 1'b1;
        cmd <= '{RD, 3'h2, 2'h0, 16'h0000};
        repeat (20) @(posedge clk_sys);
        check({15'h0, cmd_ready}, 16'h1);
        check({14'h0, scl_w, sda_w}, 16'h3);
        ce <= 1'b1;
        run(RD, 3'h2, 2'h0, 16'h0000, 16'hff80, 1'b0);
        run(SR, 3'h2, 2'h3, 16'h0000, 16'h5000, 1'b0);
        run(SR, 3'h2, 2'h2, 16'h0000, 16'h4b00, 1'b0);
        run(SR, 3'h2, 2'h1, 16'h0000, 16'h0000, 1'b0);
        run(WR, 3'h2, 2'h3, 16'h123f, 16'h0000, 1'b0);
        check({14'h0, ptr_mirror}, 16'h3);
        run(RD, 3'h2, 2'h3, 16'h0000, 16'h1230, 1'b0);
        run(WR, 3'h2, 2'h2, 16'hf5e7, 16'h0000, 1'b0);
        run(SR, 3'h2, 2'h2, 16'h0000, 16'hf5e0, 1'b0);
        run(WR, 3'h2, 2'h1, 16'h0060, 16'h0000, 1'b0);
        run(RD, 3'h2, 2'h1, 16'h0000, 16'h0060, 1'b0);
        run(PT, 3'h2, 2'h0, 16'h0000, 16'h0000, 1'b0);
        run(RD, 3'h2, 2'h0, 16'h0000, 16'hff80, 1'b0);
        run(WR, 3'h2, 2'h0, 16'h1234, 16'h0000, 1'b1);
        run(SR, 3'h5, 2'h3, 16'h0000, 16'h0000, 1'b1);
        hold_low <= 1'b1;
        run(RD, 3'h2, 2'h0, 16'h0000, 16'h0000, 1'b1);
        hold_low <= 1'b0;
        run(RD, 3'h2, 2'h0, 16'h0000, 16'hff80, 1'b0);
        check({14'h0, scl_w, sda_w}, 16'h3);
        check({15'h0, dev_u.alarm_r}, 16'h0);
        print_verdict();
    end
endmodule : tb_tsm_master
`default_nettype wire

// *** test/tsm_master_props.sv ***
// Purpose: port assertions for the sensor bus master
// Assumes: one clock domain, resetn active low, ce low only while idle
// Notes: bound into every tsm_master instance
`timescale 1ns/1ns
`default_nettype none
module tsm_master_props #(
    parameter logic [15:0] QUARTER_CYC = 16'h4
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ce,
    input wire logic cmd_valid,
    input wire tsm_pkg::tsm_cmd_t cmd,
    input wire logic cmd_ready,
    input wire logic rsp_valid,
    input wire tsm_pkg::tsm_rsp_t rsp,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic sda_out,
    input wire logic sda_oe
);
    // ****
    // helpers
    // ****
    // counts the cycles scl has been pulled low
    logic [15:0] lo_cnt_r;
    logic [15:0] lo_cnt_nxt;
    always_comb begin
        lo_cnt_nxt = scl_oe ? lo_cnt_r + 16'h1 : 16'h0;
    end
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            lo_cnt_r <= 16'h0;
        end else begin
            lo_cnt_r <= lo_cnt_nxt;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    sequence take_s;
        ce && cmd_valid && cmd_ready;
    endsequence
    sequence ro_write_s;
        take_s ##0 (cmd.op == tsm_pkg::TSM_OP_WRITE)
            ##0 (cmd.ptr == tsm_pkg::PTR_TEMP);
    endsequence
    // ****
    // assertions
    // ****
    pins_low_a: assert property (!scl_out && !sda_out)
        else $error("open drain level not low");
    ready_drop_a: assert property (take_s |=> !cmd_ready)
        else $error("ready stayed high after take");
    rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid)
        else $error("answer longer than one cycle");
    bus_released_a: assert property (rsp_valid |->
        cmd_ready && !scl_oe && !sda_oe)
        else $error("bus held at answer");
    ready_rise_a: assert property ($rose(cmd_ready) && $past(resetn, 2)
        |-> rsp_valid)
        else $error("ready rose without answer");
    ro_refuse_a: assert property (ro_write_s |=>
        (!scl_oe && !sda_oe) ##1 (rsp_valid && rsp.err && !sda_oe))
        else $error("read-only write not refused");
    start_hold_a: assert property ($rose(sda_oe) && !scl_oe
        |-> !scl_oe [*2])
        else $error("clock fell too soon after start");
    scl_low_a: assert property ($fell(scl_oe) |->
        lo_cnt_r == 16'(2 * QUARTER_CYC))
        else $error("clock low phase wrong length");
endmodule : tsm_master_props
bind tsm_master tsm_master_props #(.QUARTER_CYC(QUARTER_CYC)) u_props (
    .clk_sys(clk_sys), .resetn(resetn), .ce(ce), .cmd_valid(cmd_valid),
    .cmd(cmd), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe));
`default_nettype wire

// *** test/tsm_sensor_model.sv ***
// Purpose: behavioural temperature sensor slave on the two-wire bus
// Assumes: wires resolved by the bench with pull-ups
// Notes: conversions repeat a fixed temperature value and drive the alarm
`timescale 1ns/1ns
`default_nettype none
module tsm_sensor_model #(
    parameter logic [3:0] DEV_TYPE = 4'h5, // arbitrary type code
    parameter logic [2:0] PINS = 3'h2,
    parameter logic [15:0] TEMP = 16'hff80
) (
    input wire logic scl,
    input wire logic sda,
    output logic sda_oe = 1'b0
);
    logic [15:0] temp_r = TEMP;
    logic [15:0] upper_r = tsm_pkg::UPPER_THR_RESET;
    logic [15:0] lower_r = tsm_pkg::LOWER_THR_RESET;
    logic [7:0] conf_r = tsm_pkg::CONF_RESET;
    logic [1:0] ptr_r = tsm_pkg::PTR_RESET;
    logic [15:0] comp_r = TEMP;
    logic alarm_r = 1'b0;
    logic [7:0] sh_r = 8'h00;
    logic [7:0] msb_r = 8'h00;
    logic [15:0] tx_r = 16'hffff;
    logic act = 1'b0;
    logic rd = 1'b0;
    int n = 0;
    int st = 0;
    // ****
    // conversions
    // ****
    // every result feeds the alarm; the readable copy skips results that land during a read
    always #50000 begin
        logic [15:0] res_m;
        comp_r = TEMP;
        if (!(act && rd)) temp_r = comp_r;
        res_m = ~(16'h007f >> conf_r[6:5]);
        if ($signed(comp_r & res_m) > $signed(upper_r & res_m)) begin
            alarm_r = 1'b1;
        end else if ($signed(comp_r & res_m) < $signed(lower_r & res_m)) begin
            alarm_r = 1'b0;
        end
    end
    // ****
    // byte handling at the ninth clock
    // ****
    task automatic take_byte();
        case (st)
            0: begin
                act = (sh_r[7:1] == {DEV_TYPE, PINS});
                rd = sh_r[0];
                tx_r = (ptr_r == 2'h1) ? {conf_r, 8'hff} :
                    (ptr_r == 2'h0) ? temp_r :
                    (ptr_r == 2'h2) ? lower_r : upper_r;
            end
            1: begin
                // upper pointer bits set: abort, old pointer kept
                act = (sh_r[7:2] == 6'h00);
                if (act) ptr_r = sh_r[1:0];
            end
            2: begin
                msb_r = sh_r;
                if (ptr_r == 2'h1) conf_r = sh_r;
            end
            default: begin
                if (ptr_r == 2'h2) lower_r = {msb_r, sh_r & 8'hf0};
                if (ptr_r == 2'h3) upper_r = {msb_r, sh_r & 8'hf0};
            end
        endcase
        st = st + 1;
        sda_oe = act;
    endtask : take_byte
    // ****
    // line watchers
    // ****
    always @(negedge sda) begin
        if (scl === 1'b1) begin
            act = 1'b1;
            n = 0;
            st = 0;
            rd = 1'b0;
        end
    end
    always @(posedge sda) begin
        if (scl === 1'b1) begin
            act = 1'b0;
            sda_oe = 1'b0;
        end
    end
    always @(posedge scl) begin
        if (act) begin
            if (n < 8) sh_r = {sh_r[6:0], sda};
            else if (rd && sda) act = 1'b0;
            n = n + 1;
        end
    end
    // drive only after clock falls, so data is steady while high
    always @(negedge scl) begin
        if (act) begin
            sda_oe = 1'b0;
            if (n == 9) n = 0;
            if (n == 8 && !rd) begin
                take_byte();
            end else if (rd && n < 8) begin
                sda_oe = !tx_r[15];
                tx_r = {tx_r[14:0], 1'b1};
            end
        end
    end
endmodule : tsm_sensor_model
`default_nettype wire
